// ---- hw/adcstc_pkg.sv ----
// Package: register map, field layout and timing constants for the block
package adcstc_pkg;
    // Register byte offsets
    localparam logic [7:0] CTRL0_OFF     = 8'h00;
    localparam logic [7:0] CTRL1_OFF     = 8'h04;
    localparam logic [7:0] TRIG_OFF      = 8'h08;
    localparam logic [7:0] RESH_OFF      = 8'h0c;
    localparam logic [7:0] RESL_OFF      = 8'h10;
    localparam logic [7:0] IRQ_STAT_OFF  = 8'h14;
    localparam logic [7:0] IRQ_MASK_OFF  = 8'h18;
    localparam logic [7:0] PWR_OFF       = 8'h1c;
    // Control register 0 fields
    localparam int CTRL0_ON_BIT = 0;
    localparam int CTRL0_GO_BIT = 1;
    localparam int CTRL0_CH_LSB = 2;
    localparam logic [7:0] CTRL0_RESET = 8'h00;
    // Control register 1 fields
    localparam int CTRL1_FMT_BIT = 7;
    localparam int CTRL1_CS_LSB  = 4;
    localparam logic [7:0] CTRL1_MASK = 8'hf7;
    localparam logic [4:0] TRIG_MASK  = 5'h1f;
    // Dedicated RC clock codes
    localparam logic [1:0] CS_RC_LOW = 2'h3;
    // Channel codes
    localparam logic [5:0] CH_GND  = 6'h3c;
    localparam logic [5:0] CH_TEMP = 6'h3d;
    localparam logic [5:0] CH_DAC  = 6'h3e;
    localparam logic [5:0] CH_FVR  = 6'h3f;
    // Trigger codes at the edges of the table
    localparam logic [4:0] TRIG_NONE = 5'h00;
    localparam logic [4:0] TRIG_MAX  = 5'h11;
    // Interrupt status bit
    localparam int IRQ_DONE_BIT = 0;
    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Timing: one instruction cycle, and conversion length
    localparam int SYS_CLK_MHZ    = 100;
    localparam int INSTR_NS       = 40;
    localparam int INSTR_CYC      = (INSTR_NS * SYS_CLK_MHZ + 999) / 1000;
    localparam int CONV_TAD       = 12;
    localparam int TAD_CYC_DEF    = 4;

    typedef enum logic [1:0] {
        ADCSTC_IDLE  = 2'b00,
        ADCSTC_DELAY = 2'b01,
        ADCSTC_CONV  = 2'b11
    } adcstc_state_t;
endpackage

// ---- hw/adcstc_trig.sv ----
// Auto-trigger selector with synchroniser and rising-edge detector
`timescale 1ns/1ns
module adcstc_trig
    import adcstc_pkg::*;
(
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        reset_n,
    input  wire logic        clk_en,
    // Selection and sources
    input  wire logic [4:0]  trig_sel,
    input  wire logic [17:0] trig_src,
    // Single-cycle edge
    output logic             trig_pulse
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
    } adcstc_trig_st_t;

    adcstc_trig_st_t st_q;
    adcstc_trig_st_t st_d;
    logic            sel_bit;

    always_comb begin
        // Code zero and codes above the table select nothing
        if (trig_sel == TRIG_NONE || trig_sel > TRIG_MAX) begin // RULE8
            sel_bit = 1'b0;
        end else begin
            sel_bit = trig_src[trig_sel]; // RULE7
        end
        st_d    = st_q;
        st_d.s1 = sel_bit;
        st_d.s2 = st_q.s1; // RULE19
        st_d.s3 = st_q.s2;
        trig_pulse = st_q.s2 && !st_q.s3; // RULE19
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            st_q <= '0;
        end else if (clk_en) begin
            st_q <= st_d;
        end
    end
endmodule

// ---- hw/adcstc_top.sv ----
// Converter control: register file, sleep handling and conversion sequencer
// Contract
// (RULE1) Sleep conversion only with dedicated RC clock
// (RULE2) RC clock delays start one instruction
// (RULE3) Sleep, irq enabled: wake on completion
// (RULE4) Sleep, irq disabled: power down, on-bit stays
// (RULE5) Other clock: sleep aborts, powers down
// (RULE6) Trigger rising edge sets go flag
// (RULE7) Seventeen timer, comparator, cell, capture sources
// (RULE8) Five-bit trigger code, zero means none
// (RULE9) Software waits acquisition after channel change
// (RULE10) Hold capacitor never discharged after conversion
// (RULE11) Channel codes for ground, temp, DAC, reference
// (RULE12) Port A, B, C channel codes; others none
// (RULE13) Go flag starts, reads busy, self-clears
// (RULE14) On-bit enables converter; zero draws nothing
// (RULE15) Software configures, waits, starts, polls, reads
// (RULE16) Software clears done flag after reading
// (RULE17) Completion clears go, sets done, loads result
// (RULE18) Clock codes 011 and 111 are RC
// (RULE19) Trigger synchronised, single edge per rise
`timescale 1ns/1ns
module adcstc_top
    import adcstc_pkg::*;
#(
    parameter int TAD_CYC = TAD_CYC_DEF
) (
    // Clock, reset, enable
    input  wire logic        sys_clk,
    input  wire logic        reset_n,
    input  wire logic        clk_en,
    // AXI4-Lite write
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // System
    input  wire logic        sleep_req,
    input  wire logic [17:0] trig_src,
    output logic             wake_req,
    output logic             irq,
    // Analogue front end
    output logic             conv_power,
    output logic             conv_sample,
    output logic [5:0]       conv_channel,
    output logic             conv_start,
    input  wire logic [9:0]  conv_result
);
    typedef struct packed {
        logic          on_bit;
        logic          go;
        logic [5:0]    chan;
        logic [7:0]    ctrl1;
        logic [4:0]    trig;
        logic [9:0]    result;
        logic          stat;
        logic          mask;
        logic          pdown;
        adcstc_state_t state;
        logic [15:0]   cnt;
        logic          aw_got;
        logic [7:0]    aw_addr;
        logic          w_got;
        logic [31:0]   w_data;
        logic [3:0]    w_strb;
        logic          bvalid;
        logic [1:0]    bresp;
        logic          rvalid;
        logic [31:0]   rdata;
        logic [1:0]    rresp;
        logic          wake;
        logic          irq;
        logic          start;
        logic          pwr;
        logic          samp;
    } adcstc_st_t;

    adcstc_st_t st_q;
    adcstc_st_t st_d;
    logic       trig_pulse;

    function automatic logic is_rc(input logic [7:0] c1);
        return c1[CTRL1_CS_LSB +: 2] == CS_RC_LOW; // RULE18
    endfunction

    function automatic logic [31:0] read_reg(input adcstc_st_t s,
                                             input logic [7:0] a);
        logic [31:0] v;
        v = 32'h0000_0000;
        case (a)
            CTRL0_OFF:    v[7:0] = {s.chan, s.go, s.on_bit};
            CTRL1_OFF:    v[7:0] = s.ctrl1;
            TRIG_OFF:     v[4:0] = s.trig;
            RESH_OFF:     v[7:0] = s.ctrl1[CTRL1_FMT_BIT] ?
                                   {6'h00, s.result[9:8]} : s.result[9:2];
            RESL_OFF:     v[7:0] = s.ctrl1[CTRL1_FMT_BIT] ?
                                   s.result[7:0] : {s.result[1:0], 6'h00};
            IRQ_STAT_OFF: v[IRQ_DONE_BIT] = s.stat;
            IRQ_MASK_OFF: v[IRQ_DONE_BIT] = s.mask;
            PWR_OFF:      v[0] = s.pdown;
            default:      v = 32'h0000_0000;
        endcase
        return v;
    endfunction

    // Aligned word addresses up to the last register
    function automatic logic known(input logic [7:0] a);
        return a[1:0] == 2'h0 && a <= PWR_OFF;
    endfunction

    adcstc_trig u_trig (
        .sys_clk    (sys_clk),
        .reset_n    (reset_n),
        .clk_en     (clk_en),
        .trig_sel   (st_q.trig),
        .trig_src   (trig_src),
        .trig_pulse (trig_pulse)
    );

    always_comb begin
        logic       do_wr;
        logic       go_wr;
        logic       go_clr_wr;
        logic       done_ev;
        logic [7:0] wb;
        logic [31:0] cnt_max;
        st_d      = st_q;
        do_wr     = 1'b0;
        go_wr     = 1'b0;
        go_clr_wr = 1'b0;
        done_ev   = 1'b0;
        wb        = st_q.w_data[7:0];
        cnt_max   = 32'd0;
        st_d.start = 1'b0;
        st_d.wake  = 1'b0;

        // Write channel capture, in either order
        if (s_axi_awvalid && !st_q.aw_got) begin
            st_d.aw_got  = 1'b1;
            st_d.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !st_q.w_got) begin
            st_d.w_got  = 1'b1;
            st_d.w_data = s_axi_wdata;
            st_d.w_strb = s_axi_wstrb;
        end
        if (st_q.aw_got && st_q.w_got && !st_q.bvalid) begin
            do_wr        = st_q.w_strb[0] && known(st_q.aw_addr);
            st_d.aw_got  = 1'b0;
            st_d.w_got   = 1'b0;
            st_d.bvalid  = 1'b1;
            st_d.bresp   = known(st_q.aw_addr) ? RESP_OKAY : RESP_SLVERR;
        end
        if (st_q.bvalid && s_axi_bready) begin
            st_d.bvalid = 1'b0;
        end

        if (do_wr) begin
            case (st_q.aw_addr)
                CTRL0_OFF: begin
                    st_d.on_bit = wb[CTRL0_ON_BIT]; // RULE14
                    st_d.chan   = wb[7:CTRL0_CH_LSB]; // RULE11 RULE12
                    go_wr       = wb[CTRL0_GO_BIT]; // RULE13
                    go_clr_wr   = !wb[CTRL0_GO_BIT];
                end
                CTRL1_OFF:    st_d.ctrl1 = wb & CTRL1_MASK;
                TRIG_OFF:     st_d.trig = wb[4:0] & TRIG_MASK; // RULE8
                IRQ_MASK_OFF: st_d.mask = wb[IRQ_DONE_BIT];
                default:      st_d.trig = st_d.trig;
            endcase
        end

        // Read channel
        if (s_axi_arvalid && !st_q.rvalid) begin
            st_d.rvalid = 1'b1;
            st_d.rdata  = read_reg(st_q, s_axi_araddr);
            st_d.rresp  = known(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
        end else if (st_q.rvalid && s_axi_rready) begin
            st_d.rvalid = 1'b0;
        end

        // Conversion sequencer
        cnt_max = CONV_TAD * TAD_CYC;
        case (st_q.state)
            ADCSTC_IDLE: begin
                // Go while off is ignored; so is an edge mid-conversion
                if (st_q.on_bit && (go_wr || trig_pulse)) begin // RULE6
                    st_d.go    = 1'b1; // RULE13
                    st_d.pdown = 1'b0;
                    st_d.cnt   = 16'd0;
                    if (is_rc(st_q.ctrl1)) begin
                        st_d.state = ADCSTC_DELAY; // RULE2
                    end else begin
                        st_d.state = ADCSTC_CONV;
                        st_d.start = 1'b1;
                    end
                end
            end
            ADCSTC_DELAY: begin
                // Extra instruction lets a sleep instruction run first
                if (st_q.cnt == 16'(INSTR_CYC - 1)) begin // RULE2
                    st_d.state = ADCSTC_CONV;
                    st_d.cnt   = 16'd0;
                    st_d.start = 1'b1;
                end else begin
                    st_d.cnt = st_q.cnt + 16'd1;
                end
            end
            ADCSTC_CONV: begin
                if (st_q.cnt == 16'(cnt_max - 1)) begin
                    done_ev    = 1'b1;
                    st_d.state = ADCSTC_IDLE;
                    st_d.go    = 1'b0; // RULE17
                    st_d.result = conv_result; // RULE17
                end else begin
                    st_d.cnt = st_q.cnt + 16'd1;
                end
            end
            default: st_d.state = ADCSTC_IDLE;
        endcase

        // Software abort keeps the partial result
        if (go_clr_wr && st_q.state != ADCSTC_IDLE && !done_ev) begin
            st_d.state  = ADCSTC_IDLE;
            st_d.go     = 1'b0;
            st_d.result = conv_result;
        end

        // Sleep handling
        // Only the RC clock keeps running in Sleep
        if (sleep_req && !is_rc(st_q.ctrl1) && st_q.on_bit) begin
            st_d.pdown = 1'b1; // RULE5 RULE1
            st_d.state = ADCSTC_IDLE;
            st_d.go    = 1'b0;
        end
        if (done_ev && sleep_req) begin
            if (st_q.mask) begin
                st_d.wake = 1'b1; // RULE3
            end else begin
                st_d.pdown = 1'b1; // RULE4
            end
        end
        // Power-down ends once awake with the sequencer idle
        if (!sleep_req && st_q.pdown && st_q.state == ADCSTC_IDLE) begin
            st_d.pdown = 1'b0;
        end
        if (!st_q.on_bit) begin
            st_d.state = ADCSTC_IDLE;
            st_d.go    = 1'b0;
        end

        // Sticky done flag: set wins over write-one clear
        if (do_wr && st_q.aw_addr == IRQ_STAT_OFF && wb[IRQ_DONE_BIT]) begin
            st_d.stat = 1'b0;
        end
        if (done_ev) begin
            st_d.stat = 1'b1; // RULE17
        end
        st_d.irq = st_d.stat && st_d.mask;
        // Registered so the converter controls come straight from flops
        st_d.pwr  = st_d.on_bit && !st_d.pdown; // RULE14 RULE4
        st_d.samp = st_d.on_bit && st_d.state != ADCSTC_CONV; // RULE10
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            st_q <= '0;
        end else if (clk_en) begin
            st_q <= st_d;
        end
    end

    // Sample switch stays closed while on and outside conversion; no discharge path
    assign conv_sample   = st_q.samp; // RULE10
    assign conv_power    = st_q.pwr; // RULE14 RULE4
    assign conv_channel  = st_q.chan;
    assign conv_start    = st_q.start;
    assign wake_req      = st_q.wake;
    assign irq           = st_q.irq;
    assign s_axi_awready = !st_q.aw_got;
    assign s_axi_wready  = !st_q.w_got;
    assign s_axi_bvalid  = st_q.bvalid;
    assign s_axi_bresp   = st_q.bresp;
    assign s_axi_arready = !st_q.rvalid;
    assign s_axi_rvalid  = st_q.rvalid;
    assign s_axi_rdata   = st_q.rdata;
    assign s_axi_rresp   = st_q.rresp;
endmodule

// ---- dv/adcstc_afe_model.sv ----
// Behavioural sample-and-hold and converter facing the control block
`timescale 1ns/1ns
module adcstc_afe_model (
    // From the block
    input  wire logic       sys_clk,
    input  wire logic       conv_power,
    input  wire logic       conv_sample,
    input  wire logic [5:0] conv_channel,
    // Code back to the block
    output logic [9:0]      conv_result
);
    logic [9:0] held_q = 10'h000;
    // Tracks while sampling; charge is never cleared afterwards
    always @(posedge sys_clk) begin
        if (conv_power && conv_sample) begin
            held_q <= {4'h9, conv_channel};
        end
    end
    // Unpowered converter gives no valid code, not a stale one
    assign conv_result = conv_power ? held_q : ~held_q;
endmodule

// ---- dv/adcstc_asserts.sv ----
// Checker: port timing of the converter control block
`timescale 1ns/1ns
module adcstc_asserts #(
    parameter int TAD_CYC = 4
) (
    // Clock and reset
    input wire logic        sys_clk,
    input wire logic        reset_n,
    input wire logic        clk_en,
    // Register bus
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    // System and converter
    input wire logic        sleep_req,
    input wire logic        wake_req,
    input wire logic        conv_power,
    input wire logic        conv_sample,
    input wire logic        conv_start
);
    // Slack of two for the registered start and finish
    localparam int CONV_MAX = adcstc_pkg::CONV_TAD * TAD_CYC + 2;
    default clocking cb @(posedge sys_clk);
    endclocking
    // A frozen block stretches every window, so freezing abandons them
    default disable iff (!reset_n || !clk_en);
    sequence s_launch;
        conv_start ##1 !conv_start;
    endsequence
    sequence s_wake;
        wake_req ##1 !wake_req;
    endsequence
    a_start_pulse: assert property (conv_start |-> s_launch)
        else $error("start pulse too long");
    a_start_powered: assert property (conv_start |-> conv_power)
        else $error("start without power");
    a_start_holds: assert property (conv_start |-> ##[0:2] !conv_sample)
        else $error("sampling not stopped");
    a_conv_ends: assert property (conv_start |-> ##[1:CONV_MAX] conv_sample)
        else $error("conversion too long");
    a_wake_sleep: assert property (wake_req |-> sleep_req)
        else $error("wake outside sleep");
    a_wake_pulse: assert property (wake_req |-> s_wake)
        else $error("wake pulse too long");
    a_bresp_hold: assert property
        (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    a_rdata_hold: assert property
        (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    a_ar_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("address taken while busy");
    a_reset_quiet: assert property (!$past(reset_n) |->
        !s_axi_bvalid && !s_axi_rvalid && !wake_req && !conv_start)
        else $error("output active after reset");
endmodule

// ---- dv/adc_sleep_trigger_control_test.sv ----
// Self-checking bench for the converter control block
`timescale 1ns/1ns
module adc_sleep_trigger_control_test
    import adcstc_pkg::*;
;
    localparam int TADC = 1;
    logic        sys_clk = 1'h0, reset_n = 1'h0, sleep_req = 1'h0;
    logic        clk_en = 1'h1;
    logic [3:0]  s_axi_wstrb = 4'h1;
    logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
    logic        s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
    logic        s_axi_rready = 1'h0;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [17:0] trig_src = 18'h0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic        s_axi_rvalid, wake_req, irq, conv_power, conv_sample;
    logic        conv_start;
    logic [1:0]  s_axi_bresp, s_axi_rresp, last_resp;
    logic [31:0] s_axi_rdata;
    logic [5:0]  conv_channel;
    logic [9:0]  conv_result;
    int          error_cnt = 0, num_checks = 0, cyc = 0;
    adcstc_top #(.TAD_CYC(TADC)) DUT (
        .sys_clk, .reset_n, .clk_en,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .sleep_req, .trig_src, .wake_req, .irq, .conv_power,
        .conv_sample, .conv_channel, .conv_start, .conv_result
    );
    adcstc_afe_model u_afe (
        .sys_clk, .conv_power, .conv_sample, .conv_channel, .conv_result
    );
    always #5 sys_clk = ~sys_clk;
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            tally_and_finish();
        end
    end
    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Ready raised only after valid, so the hold of the answer is seen
    task automatic axi_wr(input logic [7:0] a, input logic [7:0] d);
        logic aw_done, w_done;
        aw_done = 1'h0;
        w_done = 1'h0;
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        while (!(aw_done && w_done)) begin
            @(posedge sys_clk);
            aw_done |= s_axi_awready;
            w_done |= s_axi_wready;
            s_axi_awvalid <= !aw_done;
            s_axi_wvalid <= !w_done;
        end
        while (s_axi_bvalid !== 1'h1) @(posedge sys_clk);
        s_axi_bready <= 1'h1;
        @(posedge sys_clk);
        last_resp = s_axi_bresp;
        s_axi_bready <= 1'h0;
    endtask
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        @(posedge sys_clk);
        while (s_axi_arready !== 1'h1) @(posedge sys_clk);
        s_axi_arvalid <= 1'h0;
        while (s_axi_rvalid !== 1'h1) @(posedge sys_clk);
        s_axi_rready <= 1'h1;
        @(posedge sys_clk);
        d = s_axi_rdata;
        last_resp = s_axi_rresp;
        s_axi_rready <= 1'h0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp,
                          input string what);
        logic [31:0] v;
        axi_rd(a, v);
        check(what, v, exp);
    endtask
    task automatic wait_done();
        logic [31:0] v;
        int n;
        v = 32'h2;
        n = 0;
        while (v[1] !== 1'h0 && n < 40) begin
            axi_rd(CTRL0_OFF, v);
            n++;
        end
        check("go cleared", {31'h0, v[1]}, 32'h0);
    endtask
    task automatic t_regs();
        rd_chk(CTRL0_OFF, 32'h0, "ctrl0 reset");
        rd_chk(IRQ_STAT_OFF, 32'h0, "status reset");
        rd_chk(8'h40, 32'h0, "unmapped read");
        check("unmapped resp", {30'h0, last_resp}, {30'h0, RESP_SLVERR});
        axi_wr(8'h40, 8'hff);
        check("unmapped wr resp", {30'h0, last_resp}, {30'h0, RESP_SLVERR});
        s_axi_wstrb <= 4'h0;
        axi_wr(IRQ_MASK_OFF, 8'h01);
        s_axi_wstrb <= 4'h1;
        rd_chk(IRQ_MASK_OFF, 32'h0, "strobe off");
        axi_wr(CTRL0_OFF, 8'h02);
        check("write resp", {30'h0, last_resp}, {30'h0, RESP_OKAY});
        rd_chk(CTRL0_OFF, 32'h0, "go while off");
        $display("test regs done");
    endtask
    task automatic t_conv();
        logic [9:0] r;
        r = {4'h9, CH_FVR};
        axi_wr(IRQ_MASK_OFF, 8'h01);
        axi_wr(CTRL0_OFF, {CH_FVR, 2'h1});
        check("channel", {26'h0, conv_channel}, {26'h0, CH_FVR});
        repeat (8) @(posedge sys_clk);
        axi_wr(CTRL0_OFF, {CH_FVR, 2'h3});
        rd_chk(CTRL0_OFF, {24'h0, CH_FVR, 2'h3}, "busy");
        wait_done();
        rd_chk(RESH_OFF, {24'h0, r[9:2]}, "result high");
        rd_chk(RESL_OFF, {24'h0, r[1:0], 6'h0}, "result low");
        axi_wr(CTRL1_OFF, 8'h80);
        rd_chk(RESH_OFF, {30'h0, r[9:8]}, "right high");
        rd_chk(RESL_OFF, {24'h0, r[7:0]}, "right low");
        rd_chk(IRQ_STAT_OFF, 32'h1, "done flag");
        check("irq set", {31'h0, irq}, 32'h1);
        axi_wr(IRQ_MASK_OFF, 8'h00);
        check("irq masked", {31'h0, irq}, 32'h0);
        axi_wr(IRQ_STAT_OFF, 8'h01);
        rd_chk(IRQ_STAT_OFF, 32'h0, "done cleared");
        $display("test conversion done");
    endtask
    task automatic t_trig();
        axi_wr(CTRL0_OFF, 8'h01);
        for (int c = 1; c <= 17; c++) begin
            axi_wr(TRIG_OFF, 8'(c));
            trig_src <= 18'h1 << c;
            repeat (4) @(posedge sys_clk);
            rd_chk(CTRL0_OFF, 32'h3, "trigger go");
            wait_done();
            repeat (6) @(posedge sys_clk);
            rd_chk(CTRL0_OFF, 32'h1, "single edge");
            trig_src <= 18'h0;
        end
        axi_wr(TRIG_OFF, {3'h0, TRIG_NONE});
        trig_src <= 18'h3ffff;
        repeat (6) @(posedge sys_clk);
        rd_chk(CTRL0_OFF, 32'h1, "no trigger");
        trig_src <= 18'h0;
        $display("test trigger done");
    endtask
    task automatic go_lat(input logic [2:0] cs, output int n);
        axi_wr(CTRL1_OFF, {1'h0, cs, 4'h0});
        n = 0;
        fork
            axi_wr(CTRL0_OFF, 8'h03);
            while (conv_start !== 1'h1 && n < 100) begin
                @(posedge sys_clk);
                n++;
            end
        join
        wait_done();
    endtask
    task automatic t_rc();
        int n0, n1, n2, n3;
        go_lat(3'h0, n0);
        go_lat(3'h3, n1);
        go_lat(3'h7, n2);
        go_lat(3'h4, n3);
        check("rc delay 011", n1, n0 + INSTR_CYC);
        check("rc delay 111", n2, n0 + INSTR_CYC);
        check("no delay 100", n3, n0);
        $display("test rc clock done");
    endtask
    task automatic t_sleep();
        int n;
        axi_wr(IRQ_STAT_OFF, 8'h01);
        axi_wr(CTRL1_OFF, 8'h30);
        axi_wr(IRQ_MASK_OFF, 8'h01);
        axi_wr(CTRL0_OFF, 8'h03);
        sleep_req <= 1'h1;
        n = 0;
        while (wake_req !== 1'h1 && n < 100) begin
            @(posedge sys_clk);
            n++;
        end
        check("wake", {31'h0, wake_req}, 32'h1);
        sleep_req <= 1'h0;
        axi_wr(IRQ_STAT_OFF, 8'h01);
        axi_wr(IRQ_MASK_OFF, 8'h00);
        axi_wr(CTRL0_OFF, 8'h03);
        sleep_req <= 1'h1;
        wait_done();
        check("sleep power", {31'h0, conv_power}, 32'h0);
        rd_chk(PWR_OFF, 32'h1, "power-down state");
        rd_chk(CTRL0_OFF, 32'h1, "on kept");
        rd_chk(IRQ_STAT_OFF, 32'h1, "done in sleep");
        sleep_req <= 1'h0;
        axi_wr(IRQ_STAT_OFF, 8'h01);
        axi_wr(CTRL1_OFF, 8'h00);
        axi_wr(CTRL0_OFF, 8'h03);
        sleep_req <= 1'h1;
        repeat (3) @(posedge sys_clk);
        check("abort power", {31'h0, conv_power}, 32'h0);
        rd_chk(CTRL0_OFF, 32'h1, "abort on kept");
        repeat (20) @(posedge sys_clk);
        rd_chk(IRQ_STAT_OFF, 32'h0, "abort no done");
        sleep_req <= 1'h0;
        $display("test sleep done");
    endtask
    // A conversion frozen mid-way must still be busy after the freeze
    task automatic t_freeze();
        axi_wr(CTRL0_OFF, 8'h03);
        clk_en <= 1'h0;
        repeat (20) @(posedge sys_clk);
        clk_en <= 1'h1;
        rd_chk(CTRL0_OFF, 32'h3, "frozen busy");
        wait_done();
        $display("test freeze done");
    endtask
    initial begin
        repeat (12) @(posedge sys_clk);
        reset_n <= 1'h1;
        @(posedge sys_clk);
        t_regs();
        t_conv();
        t_trig();
        t_rc();
        t_freeze();
        t_sleep();
        tally_and_finish();
    end
endmodule
bind adcstc_top adcstc_asserts #(.TAD_CYC(TAD_CYC)) u_chk (
    .sys_clk, .reset_n, .clk_en, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
    .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
    .sleep_req, .wake_req, .conv_power, .conv_sample, .conv_start
);
